// [hdl/sbp_axil.sv]
// AXI4-Lite register slave for the power state controller
`include "sbp_defs.svh"
module sbp_axil
  import sbp_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic [`SBP_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`SBP_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic                        wr_pulse,
  output logic [`SBP_ADDR_W-1:0]      wr_addr,
  output logic [31:0]                 wr_data,
  output logic [3:0]                  wr_strb,
  input  wire logic                   wr_hit,
  output logic [`SBP_ADDR_W-1:0]      rd_addr,
  input  wire logic [31:0]            rd_data,
  input  wire logic                   rd_hit
);

  sbp_axi_st_t q;   // Registered state
  sbp_axi_st_t d;   // Next state

  // Ready while the holding slot is empty and no answer is pending
  assign s_axi_awready = !q.aw_have && !q.bvalid;
  assign s_axi_wready  = !q.w_have && !q.bvalid;
  assign s_axi_arready = !q.rd_pend && !q.rvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rresp   = q.rresp;
  assign s_axi_rdata   = q.rdata;
  // Write commits once address and data are both held
  assign wr_pulse      = q.aw_have && q.w_have && !q.bvalid;
  assign wr_addr       = q.waddr;
  assign wr_data       = q.wdata;
  assign wr_strb       = q.wstrb;
  assign rd_addr       = q.raddr;

  // Next-state logic for both channels
  always_comb begin
    d = q;
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_have = 1'b1;
      d.waddr   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_have = 1'b1;
      d.wdata  = s_axi_wdata;
      d.wstrb  = s_axi_wstrb;
    end
    if (wr_pulse) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = wr_hit ? `SBP_RESP_OKAY : `SBP_RESP_SLVERR;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      d.rd_pend = 1'b1;
      d.raddr   = s_axi_araddr;
    end
    if (q.rd_pend) begin
      // Data captured from the decoded address one cycle after acceptance
      d.rd_pend = 1'b0;
      d.rvalid  = 1'b1;
      d.rdata   = rd_hit ? rd_data : 32'h0000_0000;
      d.rresp   = rd_hit ? `SBP_RESP_OKAY : `SBP_RESP_SLVERR;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

// [hdl/sbp_ctrl.sv]
// Secondary bus power state, clock-run and card reset controller
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`include "sbp_defs.svh"
module sbp_ctrl
  import sbp_pkg::*;
#(
  parameter logic                   SOFTOFF_BUS_STATE_SELECT    = 1'b0,   // 1: soft-off gives B2
  parameter logic                   BUS_POWER_CLOCK_CTRL_ENABLE = 1'b1,   // State-driven control
  parameter logic [`SBP_CRST_W-1:0] CRST_HOLD                   = 16'h0040 // Card reset cycles
)
(
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic [`SBP_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`SBP_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   clk_src,
  output logic                        card_clk,
  input  wire logic                   clkrun_n_in,
  output logic                        clkrun_n_out,
  output logic                        clkrun_n_oe,
  output logic                        card_reset_n,
  output logic                        slot_vcc_en,
  input  wire logic                   card_present,
  input  wire logic                   aux_power_only,
  input  wire logic                   dn_access_req,
  output logic                        dn_access_fwd,
  output logic                        dn_access_abort,
  output logic                        card_grant_enable
);

  sbp_st_t                q;          // Registered state
  sbp_st_t                d;          // Next state
  logic                   wr_pulse;   // Register write commit
  logic [`SBP_ADDR_W-1:0] wr_addr;    // Write byte address
  logic [31:0]            wr_data;    // Write data
  logic [3:0]             wr_strb;    // Write byte lanes
  logic                   wr_hit;     // Write address mapped
  logic [`SBP_ADDR_W-1:0] rd_addr;    // Read byte address
  logic [31:0]            rd_data;    // Read data mux
  logic                   rd_hit;     // Read address mapped
  logic [1:0]             bus_state;  // Secondary bus state
  logic                   want_stop;  // Bus state asks for clock off
  logic                   ctl_en;     // State-driven control active
  logic                   vcc_cut;    // Bus off removes slot Vcc
  logic                   vcc_want;   // Slot Vcc before register
  logic                   removal;    // Card removal edge
  logic                   cclk_rise;  // Source clock rising edge
  logic                   gate_want;  // Clock should run

  // Register bus slave
  sbp_axil u_axil (
    .clk           (clk),
    .reset         (reset),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_pulse      (wr_pulse),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_hit        (wr_hit),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_hit        (rd_hit)
  );

  // Word-aligned decode; low address bits ignored
  function automatic logic is_reg(input logic [`SBP_ADDR_W-1:0] a, input logic [`SBP_ADDR_W-1:0] off);
    is_reg = ({a[`SBP_ADDR_W-1:2], 2'b00} == off);
  endfunction

  assign wr_hit = is_reg(wr_addr, `SBP_OFF_PMCS) || is_reg(wr_addr, `SBP_OFF_BSE) ||
                  is_reg(wr_addr, `SBP_OFF_SLOT) || is_reg(wr_addr, `SBP_OFF_STAT);
  assign rd_hit = is_reg(rd_addr, `SBP_OFF_PMCS) || is_reg(rd_addr, `SBP_OFF_BSE) ||
                  is_reg(rd_addr, `SBP_OFF_SLOT) || is_reg(rd_addr, `SBP_OFF_STAT);

  // Bus state follows the power state field; loss of main power forces B3
  always_comb begin
    if (q.ax_s2) begin
      bus_state = `SBP_BUS_B3;
    end else begin
      unique case (q.pm)
        `SBP_PM_D0: bus_state = `SBP_BUS_B0;
        `SBP_PM_D1: bus_state = `SBP_BUS_B1;
        `SBP_PM_D2: bus_state = `SBP_BUS_B2;
        `SBP_PM_D3: bus_state = SOFTOFF_BUS_STATE_SELECT ? `SBP_BUS_B2 : `SBP_BUS_B3;
      endcase
    end
  end

  // Control enable is fixed; with it clear an outside scheme owns clock and power
  assign ctl_en    = BUS_POWER_CLOCK_CTRL_ENABLE;
  assign want_stop = ctl_en && (bus_state == `SBP_BUS_B2 || bus_state == `SBP_BUS_B3);
  // Vcc cut only in programmed bus off, and only when software allows it
  assign vcc_cut   = ctl_en && q.bus_off_en && q.pm == `SBP_PM_D3 && bus_state == `SBP_BUS_B3;
  assign vcc_want  = q.vcc_set && !q.ax_s2 && !vcc_cut;
  assign removal   = q.cp_prev && !q.cp_s2;
  assign cclk_rise = q.ck_s2 && !q.ck_prev;
  // Clock runs in negotiation and wake; never in deep-off
  assign gate_want = !q.ax_s2 && (q.cr == SBP_CR_RUN || q.cr == SBP_CR_REQ || q.cr == SBP_CR_WAKE);

  // Register read mux; reserved bits read as zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (is_reg(rd_addr, `SBP_OFF_PMCS)) begin
      rd_data[`SBP_PMCS_PM_LO +: 2] = bus_state == `SBP_BUS_B3 && q.ax_s2 ? `SBP_PM_D3 : q.pm;
      rd_data[`SBP_PMCS_WAKE]       = q.wake_en;
    end else if (is_reg(rd_addr, `SBP_OFF_BSE)) begin
      rd_data[`SBP_BSE_SEL] = SOFTOFF_BUS_STATE_SELECT;
      rd_data[`SBP_BSE_EN]  = BUS_POWER_CLOCK_CTRL_ENABLE;
    end else if (is_reg(rd_addr, `SBP_OFF_SLOT)) begin
      rd_data[`SBP_SLOT_VCC]  = q.vcc_set;
      rd_data[`SBP_SLOT_OFF]  = q.bus_off_en;
      rd_data[`SBP_SLOT_DENY] = q.deny_en;
    end else if (is_reg(rd_addr, `SBP_OFF_STAT)) begin
      rd_data[`SBP_STAT_BUS_LO +: 2] = bus_state;
      rd_data[`SBP_STAT_CLK]         = q.gate;
      rd_data[`SBP_STAT_CRST]        = q.crst_on;
      rd_data[`SBP_STAT_VCC]         = q.vcc_on;
      rd_data[`SBP_STAT_REMOVED]     = q.removed;
      rd_data[`SBP_STAT_PRESENT]     = q.cp_s2;
    end
  end

  // Next-state logic for the whole controller
  always_comb begin
    d = q;
    // Two-stage synchronisers for clk_src, clkrun_n_in, card_present and aux_power_only
    d.ck_s1   = clk_src;
    d.ck_s2   = q.ck_s1;
    d.ck_prev = q.ck_s2;
    d.cr_s1   = clkrun_n_in;
    d.cr_s2   = q.cr_s1;
    d.cp_s1   = card_present;
    d.cp_s2   = q.cp_s1;
    d.cp_prev = q.cp_s2;
    d.ax_s1   = aux_power_only;
    d.ax_s2   = q.ax_s1;

    // Software writes; state field two bits wide
    if (wr_pulse) begin
      if (is_reg(wr_addr, `SBP_OFF_PMCS)) begin
        if (wr_strb[0]) begin
          d.pm = wr_data[`SBP_PMCS_PM_LO +: 2];
        end
        if (wr_strb[1]) begin
          d.wake_en = wr_data[`SBP_PMCS_WAKE];
        end
      end else if (is_reg(wr_addr, `SBP_OFF_SLOT) && wr_strb[0]) begin
        // Slot setting only changes by software or removal
        d.vcc_set    = wr_data[`SBP_SLOT_VCC];
        d.bus_off_en = wr_data[`SBP_SLOT_OFF];
        d.deny_en    = wr_data[`SBP_SLOT_DENY];
      end else if (is_reg(wr_addr, `SBP_OFF_STAT) && wr_strb[0] && wr_data[`SBP_STAT_REMOVED]) begin
        d.removed = 1'b0;
      end
    end
    // Removal drops slot power; the event beats a same-cycle write or clear
    if (removal) begin
      d.vcc_set = 1'b0;
      d.removed = 1'b1;
    end

    // Clock gate changes only while the source is low, so no runt pulse
    // Deep-off cuts at once: with main power gone no card can see a runt
    if (!q.ck_s2 || q.ax_s2) begin
      d.gate = gate_want;
    end
    d.cclk = q.gate && q.ck_s2;

    // Clock-run negotiation
    unique case (q.cr)
      SBP_CR_RUN: begin
        d.win_cnt = '0;
        if (want_stop && q.pm == `SBP_PM_D3) begin
          d.cr = SBP_CR_OFF;
        end else if (want_stop) begin
          d.cr    = SBP_CR_REQ;
          // Our own pull is still in the synchroniser; start it at the released
          // level so the bridge never reads its own drive as a card refusal
          d.cr_s1 = 1'b1;
          d.cr_s2 = 1'b1;
        end
      end
      SBP_CR_REQ: begin
        // Released line: card holding it low refuses the stop
        if (!want_stop || !q.cr_s2) begin
          d.cr = SBP_CR_RUN;
        end else if (q.win_cnt == `SBP_CR_WIN) begin
          d.cr = SBP_CR_STOP;
        end else if (cclk_rise) begin
          d.win_cnt = q.win_cnt + 1'b1;
        end
      end
      SBP_CR_STOP: begin
        if (q.pm == `SBP_PM_D3) begin
          d.cr = SBP_CR_OFF;
        end else if (!want_stop) begin
          d.cr = SBP_CR_WAKE;
        end else if (!q.cr_s2 && !q.deny_en) begin
          d.cr = SBP_CR_WAKE;
        end
        // With deny set the card request is ignored in B2
      end
      SBP_CR_WAKE: begin
        d.cr = SBP_CR_RUN;
      end
      SBP_CR_OFF: begin
        if (!want_stop) begin
          d.cr = SBP_CR_WAKE;
        end else if (q.pm != `SBP_PM_D3) begin
          d.cr = SBP_CR_STOP;
        end
      end
    endcase

    // Slot power and card reset; reset reloads on every Vcc return
    d.vcc_on = vcc_want;
    if (q.ax_s2 || !q.vcc_on) begin
      d.crst_cnt = CRST_HOLD;
    end else if (q.crst_cnt != '0) begin
      d.crst_cnt = q.crst_cnt - 1'b1;
    end
    d.crst_on = (d.crst_cnt != '0);

    // Downstream accesses pass only in B0, else master abort
    d.dn_fwd   = dn_access_req && bus_state == `SBP_BUS_B0;
    d.dn_abort = dn_access_req && bus_state != `SBP_BUS_B0;
  end

  // State register; system reset brings D0 and B0 with card reset held
  always_ff @(posedge clk) begin
    if (reset) begin
      q          <= '0;
      q.vcc_set  <= `SBP_VCC_SET_RST;
      q.crst_cnt <= CRST_HOLD;
      q.crst_on  <= 1'b1;
      q.cr       <= SBP_CR_RUN;
    end else begin
      q <= d;
    end
  end

  // Outputs; clock-run is open drain and never driven in D3
  assign card_clk          = q.cclk;
  assign clkrun_n_out      = 1'b0;
  assign clkrun_n_oe       = (q.cr == SBP_CR_RUN || q.cr == SBP_CR_WAKE) && q.pm != `SBP_PM_D3 && ctl_en;
  assign card_reset_n      = !q.crst_on;
  assign slot_vcc_en       = q.vcc_on;
  assign dn_access_fwd     = q.dn_fwd;
  assign dn_access_abort   = q.dn_abort;
  // Card may not start traffic outside B0, which lets the arbiter sleep
  assign card_grant_enable = bus_state == `SBP_BUS_B0;

  // Reset release sequence
  sequence s_rst_release;
    reset ##1 !reset;
  endsequence

  // Slot power returning
  sequence s_vcc_return;
    !slot_vcc_en ##1 slot_vcc_en;
  endsequence

  a_reset_bus_b0: assert property (@(posedge clk) s_rst_release |-> bus_state == `SBP_BUS_B0 || q.ax_s2)
    else $error("bus not B0 after reset");
  a_reset_crst_on: assert property (@(posedge clk) s_rst_release |-> !card_reset_n)
    else $error("card reset not held after reset");
  a_vcc_ret_crst: assert property (@(posedge clk) disable iff (reset)
      s_vcc_return |-> !card_reset_n [*3])
    else $error("no card reset after Vcc return");
  a_removal_vcc: assert property (@(posedge clk) disable iff (reset)
      removal |=> !q.vcc_set ##1 !slot_vcc_en)
    else $error("removal kept slot Vcc");
  a_d0_keep_vcc: assert property (@(posedge clk) disable iff (reset)
      (q.pm != `SBP_PM_D0 && d.pm == `SBP_PM_D0 && !removal && !(wr_pulse && is_reg(wr_addr, `SBP_OFF_SLOT)))
      |=> q.vcc_set == $past(q.vcc_set))
    else $error("return to D0 changed Vcc setting");
  a_aux_deep_off: assert property (@(posedge clk) disable iff (reset)
      q.ax_s2 [*3] |-> !card_reset_n && !slot_vcc_en && !q.gate)
    else $error("deep-off not holding card");
  a_b2_clock_low: assert property (@(posedge clk) disable iff (reset)
      !q.gate ##1 !q.gate |-> !card_clk)
    else $error("card clock runs while gated");
  a_abort_not_b0: assert property (@(posedge clk) disable iff (reset)
      dn_access_req && bus_state != `SBP_BUS_B0 |=> dn_access_abort && !dn_access_fwd)
    else $error("access beyond idle bus not aborted");
  a_deny_run: assert property (@(posedge clk) disable iff (reset)
      q.cr == SBP_CR_REQ && want_stop && !q.cr_s2 |=> q.cr == SBP_CR_RUN && clkrun_n_oe)
    else $error("card refusal ignored");
  a_no_clkrun_d3: assert property (@(posedge clk) disable iff (reset)
      $rose(q.pm == `SBP_PM_D3) |-> !clkrun_n_oe ##1 !clkrun_n_oe)
    else $error("clock-run driven in D3");
  a_softoff_stop: assert property (@(posedge clk) disable iff (reset)
      ctl_en && $rose(q.pm == `SBP_PM_D3) && !q.ax_s2 |-> ##[1:12] !q.gate)
    else $error("clock not stopped in soft-off");
  a_b1_no_claim: assert property (@(posedge clk) disable iff (reset)
      dn_access_req && bus_state == `SBP_BUS_B1 |=> !dn_access_fwd)
    else $error("downstream access claimed in B1");

endmodule

// [hdl/sbp_defs.svh]
// Constants for the secondary bus power state controller
// Operation
// - Primary reset asserts card reset on powered slots
// - Return to D0 keeps slot Vcc setting
// - Bus off may run on auxiliary power
// - Programmable bus off control is optional
// - System reset returns bus to B0
// - Power loss gives B3, else software writes
// - Soft-off may place bus in B3
// - Bridge drives and controls secondary clock
// - Power state field reads and sets bus state
// - D0 to B0, D1 to B1, D2 stops clock
// - Soft-off B3 stops clock, may drop Vcc
// - Read-only bit picks B2 or B3 at soft-off
// - Read-only enable for state-driven power control
// - In B1 card initiates no traffic
// - Clock stop asks card through clock-run
// - Card clock-run request restarts the clock
// - Bridge may deny restart in B2
// - No clock-run use in D3
// - Access beyond non-B0 bus master aborts
// - B2 keeps Vcc, clock held low
// - B1 claims no downstream accesses
`ifndef SBP_DEFS_SVH
`define SBP_DEFS_SVH

`define SBP_ADDR_W        8
`define SBP_OFF_PMCS      8'h00
`define SBP_OFF_BSE       8'h04
`define SBP_OFF_SLOT      8'h08
`define SBP_OFF_STAT      8'h0c

`define SBP_PM_D0         2'h0
`define SBP_PM_D1         2'h1
`define SBP_PM_D2         2'h2
`define SBP_PM_D3         2'h3
`define SBP_BUS_B0        2'h0
`define SBP_BUS_B1        2'h1
`define SBP_BUS_B2        2'h2
`define SBP_BUS_B3        2'h3

`define SBP_PMCS_PM_LO    0
`define SBP_PMCS_WAKE     8
`define SBP_BSE_SEL       0
`define SBP_BSE_EN        1
`define SBP_SLOT_VCC      0
`define SBP_SLOT_OFF      1
`define SBP_SLOT_DENY     2
`define SBP_STAT_BUS_LO   0
`define SBP_STAT_CLK      2
`define SBP_STAT_CRST     3
`define SBP_STAT_VCC      4
`define SBP_STAT_REMOVED  5
`define SBP_STAT_PRESENT  6

`define SBP_VCC_SET_RST   1'b1
`define SBP_CRST_W        16
`define SBP_WIN_W         4
`define SBP_CR_WIN        4'h4

`define SBP_RESP_OKAY     2'h0
`define SBP_RESP_SLVERR   2'h2

`endif

// [hdl/sbp_pkg.sv]
// Types for the secondary bus power state controller
`include "sbp_defs.svh"
package sbp_pkg;

  // Clock-run negotiation states, one-hot
  typedef enum logic [4:0] {
    SBP_CR_RUN  = 5'h01,
    SBP_CR_REQ  = 5'h02,
    SBP_CR_STOP = 5'h04,
    SBP_CR_WAKE = 5'h08,
    SBP_CR_OFF  = 5'h10
  } sbp_cr_t;

  // Controller state
  typedef struct packed {
    logic [1:0]             pm;
    logic                   wake_en;
    logic                   vcc_set;
    logic                   bus_off_en;
    logic                   deny_en;
    logic                   removed;
    logic                   cr_s1;
    logic                   cr_s2;
    logic                   ck_s1;
    logic                   ck_s2;
    logic                   cp_s1;
    logic                   cp_s2;
    logic                   cp_prev;
    logic                   ax_s1;
    logic                   ax_s2;
    logic                   gate;
    logic                   cclk;
    logic                   ck_prev;
    logic                   vcc_on;
    logic                   crst_on;
    logic [`SBP_CRST_W-1:0] crst_cnt;
    logic [`SBP_WIN_W-1:0]  win_cnt;
    sbp_cr_t                cr;
    logic                   dn_fwd;
    logic                   dn_abort;
  } sbp_st_t;

  // AXI4-Lite slave state
  typedef struct packed {
    logic                   aw_have;
    logic                   w_have;
    logic [`SBP_ADDR_W-1:0] waddr;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rd_pend;
    logic [`SBP_ADDR_W-1:0] raddr;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [31:0]            rdata;
  } sbp_axi_st_t;

endpackage

// [testbench/sbp_card_model.sv]
// Card function model on the clock-run line
module sbp_card_model (
  input  wire logic clk,
  input  wire logic bridge_oe,
  input  wire logic want_clk,
  output logic      line_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic card_low = 1'b0; // Card pull-down
  // Card asks for the clock only when told; never in D3
  always_ff @(posedge clk) begin
    card_low <= want_clk;
  end
  // Stop grant is silence; pull-up when nobody drives
  assign line_n = !(bridge_oe || card_low);
endmodule

// [testbench/tb_top.sv]
// Testbench for the secondary bus power state controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = '0, reset = '1, clk_src = '0, want = '0, card_present = '1, aux_power_only = '0;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_v;
  logic [3:0] s_axi_wstrb = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, card_clk, clkrun_n_in;
  logic clkrun_n_out, clkrun_n_oe, card_reset_n, slot_vcc_en, dn_access_req = '0;
  logic dn_access_fwd, dn_access_abort, card_grant_enable;
  int fails = 0, n_tests = 0, i, k;
  sbp_ctrl #(.CRST_HOLD(16'h0004)) dut (.*);
  sbp_card_model card (.clk(clk), .bridge_oe(clkrun_n_oe), .want_clk(want), .line_n(clkrun_n_in));
  always #10 clk = ~clk;
  always #80 clk_src = ~clk_src;
  task automatic results;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tmo;
    fails++;
    results();
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  // Both channels offered together, each dropped once taken
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= '1;
    s_axi_awvalid <= '1; s_axi_wvalid <= '1; s_axi_bready <= '1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= '0;
      if (s_axi_wready) s_axi_wvalid <= '0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= '0;
    if (i == 50) tmo();
    chk("bresp", 0, s_axi_bresp);
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a; s_axi_arvalid <= '1; s_axi_rready <= '1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= '0;
      if (s_axi_rvalid) break;
    end
    rd_v = s_axi_rdata; rs = s_axi_rresp;
    s_axi_rready <= '0;
    if (i == 50) tmo();
  endtask
  // Poll one status bit until it reaches v
  task automatic pst(int b, logic v);
    for (k = 0; k < 40; k++) begin
      rd(8'h0c);
      if (rd_v[b] === v) break;
    end
    if (k == 40) tmo();
  endtask
  task automatic dn(logic ab);
    @(posedge clk) dn_access_req <= '1;
    @(posedge clk) dn_access_req <= '0;
    @(posedge clk) chk("abort", ab, dn_access_abort);
    chk("fwd", !ab, dn_access_fwd);
  endtask
  task automatic low_clk;
    for (k = 0; k < 30; k++) @(posedge clk) if (card_clk !== 1'b0) break;
    chk("cclk_low", 30, k);
  endtask
  task automatic s_base;
    pst(3, '0);
    chk("status", 32'h54, rd_v);
    rd(8'h04);
    chk("bse", 32'h2, rd_v);
    rd(8'h40);
    chk("resp", 2'h2, rs);
    dn('0);
  endtask
  task automatic s_d1;
    wr(8'h00, 32'h101);
    rd(8'h00);
    chk("pm", 32'h101, rd_v);
    chk("grant", 0, card_grant_enable);
    dn('1);
  endtask
  task automatic s_d2;
    wr(8'h00, 32'h2);
    pst(2, '0);
    chk("status", 32'h52, rd_v);
    low_clk();
    want <= '1;
    pst(2, '1);
    chk("gate", 1, rd_v[2]);
    want <= '0;
    wr(8'h08, 32'h5);
    pst(2, '0);
    want <= '1;
    repeat (40) @(posedge clk);
    rd(8'h0c);
    chk("deny", 0, rd_v[2]);
    want <= '0;
  endtask
  task automatic s_d3;
    wr(8'h08, 32'h3);
    wr(8'h00, 32'h3);
    pst(4, '0);
    chk("bus", 3, rd_v[1:0]);
    chk("oe", 0, clkrun_n_oe);
    wr(8'h00, 32'h0);
    pst(3, '0);
    chk("status", 32'h54, rd_v);
    rd(8'h08);
    chk("slot", 32'h3, rd_v);
  endtask
  task automatic s_aux;
    aux_power_only <= '1;
    repeat (8) @(posedge clk);
    chk("crst_n", 0, card_reset_n);
    low_clk();
    rd(8'h0c);
    chk("bus", 3, rd_v[1:0]);
    reset <= '1;
    repeat (4) @(posedge clk);
    reset <= '0;
    aux_power_only <= '0;
    @(posedge clk) chk("crst_n", 0, card_reset_n);
    pst(3, '0);
    chk("status", 32'h54, rd_v);
  endtask
  // Card pulled: Vcc drops, sticky flag clears by write, Vcc back by software
  task automatic s_rem;
    card_present <= '0;
    repeat (6) @(posedge clk);
    chk("vcc_en", 0, slot_vcc_en);
    rd(8'h0c);
    chk("status", 32'h2c, rd_v);
    wr(8'h0c, 32'h20);
    rd(8'h0c);
    chk("removed", 0, rd_v[5]);
    card_present <= '1;
    wr(8'h08, 32'h1);
    pst(3, '0);
    chk("status", 32'h54, rd_v);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset <= '0;
    s_base();
    s_d1();
    s_d2();
    s_d3();
    s_aux();
    s_rem();
    results();
  end
endmodule
